// ### design/pmsr_regs.sv
// Output mux, slip-prevention control and read-only status registers of the synthesizer.
// Assumes all source signals and the register port are synchronous to clk_sys.
//
// Summary of operation
// - Four-bit select field picks which internal signals reach the three output pins.
// - Select 0000 drives pins 3,2,1 from static data bits 2,1,0.
// - Select 0001 gives external reference, divided reference, divided oscillator clocks.
// - Select 0010 gives detector up pulse, down pulse, lock one-shot window.
// - Select 0011 gives reference and oscillator saturation strobes, then max-gain strobe.
// - Select 0100 gives external reference, sine reference, synced fraction strobe.
// - Select 0110 gives modulator integrator bits 1,2,3 on pins 3,2,1.
// - Select 0111 gives auxiliary clock, ring-oscillator test output, modulator clock.
// - Select 1000 drives pin 3 low, pin 2 sweep-active, pin 1 reserved.
// - Select 1010 gives quantizer bits third, second, least significant.
// - Drive-enable bit 7 enables pin drivers; cleared leaves pins undriven.
// - Per-pin disable bits turn off pin 1, 2, 3 drivers; 000 keeps all.
// - Four-bit slip adjust field sets cycles of correction; zero disables.
// - Force bit set: detector reset follows software bit; else slip logic controls.
// - Reset-release bit resets to one, enables slip prevention with register 1 bit 15.
// - Status bit 0 reads one when locked.
// - Status bits 3:1 read one when a modulator overflow occurred.
// - Status bit 5 is set while a sweep runs, cleared otherwise.
// - Temperature code is floor((T+40)/17.5), saturating at 7 and 0.
`timescale 1ns/1ns
module pmsr_regs (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [23:0] reg_wdata,
	output logic      [23:0] reg_rdata_q,
	output logic             reg_rvalid_q,
	input  wire logic        xref_clk,
	input  wire logic        ref_div_clk,
	input  wire logic        osc_div_clk,
	input  wire logic        detector_up_pulse,
	input  wire logic        detector_down_pulse,
	input  wire logic        lock_window,
	input  wire logic        sat_ref_strobe,
	input  wire logic        sat_osc_strobe,
	input  wire logic        max_gain_strobe,
	input  wire logic        sine_ref,
	input  wire logic        synced_fraction_strobe,
	input  wire logic [3:1]  modulator_integrator_bits,
	input  wire logic        aux_clk,
	input  wire logic        ring_osc_test,
	input  wire logic        modulator_clock,
	input  wire logic [2:0]  quantizer_out,
	input  wire logic        locked_flag,
	input  wire logic [2:0]  modulator_overflow_flags,
	input  wire logic        sweep_active_status,
	input  wire logic        loop_reg1_bit15,
	input  wire logic        slip_logic_reset_n,
	input  wire logic        tsens_strobe,
	input  wire logic signed [7:0] temp_celsius,
	output logic      [3:1]  gpo_out_q,
	output logic      [3:1]  gpo_oe_n_q,
	output logic             detector_reset_n_q,
	output logic      [3:0]  slip_cycle_adjust_q,
	output logic             slip_prevention_q,
	output logic             tsens_enable_q
);
	logic [pmsr_pkg::OCTRL_W-1:0] octrl_q;
	logic [pmsr_pkg::SLIP_W-1:0]  slip_q;
	logic [6:0]                   temp_q;
	logic [3:1]                   gpo_d;
	logic [23:0]                  rdata_d;

	// Integer degrees in, so -22 still yields code 1 and -23 yields 0
	function automatic logic [6:0] temp_code(input logic signed [7:0] t);
		int v;
		v = 2 * int'(t) + pmsr_pkg::TEMP_OFS2;
		if (v < 0) begin
			temp_code = 7'h00;
		end else if ((v / pmsr_pkg::TEMP_DIV2) >= int'(pmsr_pkg::TEMP_MAX)) begin
			temp_code = pmsr_pkg::TEMP_MAX;
		end else begin
			temp_code = 7'(v / pmsr_pkg::TEMP_DIV2);
		end
	endfunction

	// Register writes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			octrl_q <= pmsr_pkg::OCTRL_W'(pmsr_pkg::RST_OUT_CTRL);
		end else if (reg_wr_en && reg_addr == pmsr_pkg::ADDR_OUT_CTRL) begin
			octrl_q <= reg_wdata[pmsr_pkg::OCTRL_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			slip_q <= pmsr_pkg::RST_SLIP_CTRL;
		end else if (reg_wr_en && reg_addr == pmsr_pkg::ADDR_SLIP_CTRL) begin
			slip_q <= reg_wdata[pmsr_pkg::SLIP_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tsens_enable_q <= 1'b0;
		end else if (reg_wr_en && reg_addr == pmsr_pkg::ADDR_TSENS_EN) begin
			tsens_enable_q <= reg_wdata[0];
		end
	end

	// Reading only updates on a strobe while enabled, so the sensor may sleep otherwise
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			temp_q <= pmsr_pkg::RST_TEMP;
		end else if (tsens_enable_q && tsens_strobe) begin
			temp_q <= temp_code(temp_celsius);
		end
	end

	// Output source select
	always_comb begin
		gpo_d = 3'b000;
		case (octrl_q[pmsr_pkg::SEL_MSB:pmsr_pkg::SEL_LSB])
			pmsr_pkg::PMSR_SEL_STATIC: begin
				gpo_d = octrl_q[pmsr_pkg::SDATA_MSB:pmsr_pkg::SDATA_LSB];
			end
			pmsr_pkg::PMSR_SEL_CLOCKS: begin
				gpo_d = {xref_clk, ref_div_clk, osc_div_clk};
			end
			pmsr_pkg::PMSR_SEL_DETECT: begin
				gpo_d = {detector_up_pulse, detector_down_pulse, lock_window};
			end
			pmsr_pkg::PMSR_SEL_SAT: begin
				gpo_d = {sat_ref_strobe, sat_osc_strobe, max_gain_strobe};
			end
			pmsr_pkg::PMSR_SEL_REFSIN: begin
				gpo_d = {xref_clk, sine_ref, synced_fraction_strobe};
			end
			pmsr_pkg::PMSR_SEL_INTEG: begin
				gpo_d = {modulator_integrator_bits[1], modulator_integrator_bits[2],
					modulator_integrator_bits[3]};
			end
			pmsr_pkg::PMSR_SEL_AUX: begin
				gpo_d = {aux_clk, ring_osc_test, modulator_clock};
			end
			pmsr_pkg::PMSR_SEL_SWEEP: begin
				gpo_d = {1'b0, sweep_active_status, 1'b0};
			end
			pmsr_pkg::PMSR_SEL_QUANT: begin
				gpo_d = quantizer_out;
			end
			default: begin
				gpo_d = 3'b000;
			end
		endcase
	end

	// Registered pins add one cycle; fast clocks are resampled at clk_sys rate
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			gpo_out_q <= 3'b000;
		end else begin
			gpo_out_q <= gpo_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			gpo_oe_n_q <= 3'b111;
		end else begin
			gpo_oe_n_q <= ~({3{octrl_q[pmsr_pkg::DRV_EN]}}
				& ~octrl_q[pmsr_pkg::DIS_MSB:pmsr_pkg::DIS_LSB]);
		end
	end

	// Detector reset and slip prevention
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			detector_reset_n_q  <= 1'b1;
			slip_cycle_adjust_q <= 4'h0;
			slip_prevention_q   <= 1'b0;
		end else begin
			detector_reset_n_q  <= slip_q[pmsr_pkg::FORCE_BIT] ? slip_q[pmsr_pkg::RSTB_BIT]
				: slip_logic_reset_n;
			slip_cycle_adjust_q <= slip_q[pmsr_pkg::ADJ_MSB:pmsr_pkg::ADJ_LSB];
			slip_prevention_q   <= slip_q[pmsr_pkg::RSTB_BIT] && loop_reg1_bit15
				&& (slip_q[pmsr_pkg::ADJ_MSB:pmsr_pkg::ADJ_LSB] != 4'h0);
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 24'h000000;
		case (reg_addr)
			pmsr_pkg::ADDR_OUT_CTRL: begin
				rdata_d = 24'(octrl_q);
			end
			pmsr_pkg::ADDR_SLIP_CTRL: begin
				rdata_d = 24'(slip_q);
			end
			pmsr_pkg::ADDR_TSENS_EN: begin
				rdata_d = {23'h000000, tsens_enable_q};
			end
			pmsr_pkg::ADDR_STATUS: begin
				rdata_d[pmsr_pkg::ST_LOCK] = locked_flag;
				rdata_d[pmsr_pkg::ST_OVF_H:pmsr_pkg::ST_OVF_L] = modulator_overflow_flags;
				rdata_d[pmsr_pkg::ST_SWEEP] = sweep_active_status;
			end
			pmsr_pkg::ADDR_RSVD_20: begin
				rdata_d = pmsr_pkg::VAL_RSVD_20;
			end
			pmsr_pkg::ADDR_TEMP_RD: begin
				rdata_d = {17'h00000, temp_q};
			end
			default: begin
				rdata_d = 24'h000000;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata_q  <= 24'h000000;
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata_q <= rdata_d;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Pin routing; pins lag the select and the sources by one registered stage
	a_static_data: assert property (octrl_q[3:0] == 4'h0 |=> gpo_out_q == $past(octrl_q[6:4]))
		else $error("static data not on pins");
	a_clock_route: assert property (octrl_q[3:0] == 4'h1
		|=> gpo_out_q == $past({xref_clk, ref_div_clk, osc_div_clk}))
		else $error("clock routing wrong");
	a_detect_route: assert property (octrl_q[3:0] == 4'h2
		|=> gpo_out_q == $past({detector_up_pulse, detector_down_pulse, lock_window}))
		else $error("detector routing wrong");
	a_sat_route: assert property (octrl_q[3:0] == 4'h3
		|=> gpo_out_q == $past({sat_ref_strobe, sat_osc_strobe, max_gain_strobe}))
		else $error("saturation routing wrong");
	a_refsin_route: assert property (octrl_q[3:0] == 4'h4
		|=> gpo_out_q == $past({xref_clk, sine_ref, synced_fraction_strobe}))
		else $error("sine reference routing wrong");
	a_integ_order: assert property (octrl_q[3:0] == 4'h6
		|=> gpo_out_q == $past({modulator_integrator_bits[1], modulator_integrator_bits[2],
			modulator_integrator_bits[3]}))
		else $error("integrator bit order wrong");
	a_aux_route: assert property (octrl_q[3:0] == 4'h7
		|=> gpo_out_q == $past({aux_clk, ring_osc_test, modulator_clock}))
		else $error("auxiliary routing wrong");
	a_sweep_pins: assert property (octrl_q[3:0] == 4'h8
		|=> gpo_out_q[3] == 1'b0 && gpo_out_q[2] == $past(sweep_active_status)
		&& gpo_out_q[1] == 1'b0)
		else $error("sweep select pins wrong");
	a_quant_route: assert property (octrl_q[3:0] == 4'ha
		|=> gpo_out_q == $past(quantizer_out))
		else $error("quantizer routing wrong");
	a_reserved_low: assert property (octrl_q[3:0] == 4'h5 || octrl_q[3:0] == 4'h9
		|| octrl_q[3:0] > 4'ha |=> gpo_out_q == 3'b000)
		else $error("reserved select not low");

	// Pin drivers
	a_drive_off: assert property (!octrl_q[7] |=> gpo_oe_n_q == 3'b111)
		else $error("pins driven while disabled");
	a_pin_disable: assert property (octrl_q[7] |=> gpo_oe_n_q == $past(octrl_q[10:8]))
		else $error("per-pin disable wrong");
	a_all_driven: assert property (octrl_q[7] && octrl_q[10:8] == 3'b000
		|=> gpo_oe_n_q == 3'b000)
		else $error("pins not all driven");

	// Slip prevention; rst_n in an antecedent keeps the release edge out
	a_adjust_copy: assert property (rst_n |=> slip_cycle_adjust_q == $past(slip_q[3:0]))
		else $error("slip adjust copy wrong");
	a_slip_zero: assert property (slip_q[3:0] == 4'h0 |=> !slip_prevention_q)
		else $error("slip prevention on with zero adjust");
	a_force_reset: assert property (slip_q[4] |=> detector_reset_n_q == $past(slip_q[5]))
		else $error("forced detector reset wrong");
	a_auto_reset: assert property (rst_n && !slip_q[4]
		|=> detector_reset_n_q == $past(slip_logic_reset_n))
		else $error("auto detector reset wrong");
	a_slip_gate: assert property (slip_prevention_q
		|-> $past(loop_reg1_bit15) && $past(slip_q[5]) && slip_cycle_adjust_q != 4'h0)
		else $error("slip prevention enabled without conditions");
	a_slip_enable: assert property (slip_q[5] && loop_reg1_bit15
		&& slip_q[3:0] != 4'h0 |=> slip_prevention_q)
		else $error("slip prevention not enabled");

	// Register port
	a_octrl_write: assert property (reg_wr_en && reg_addr == 6'h1b
		|=> octrl_q == $past(reg_wdata[10:0]))
		else $error("output control write lost");
	a_slip_write: assert property (reg_wr_en && reg_addr == 6'h1c
		|=> slip_q == $past(reg_wdata[5:0]))
		else $error("slip control write lost");
	a_ro_write: assert property (reg_wr_en && reg_addr == 6'h1f
		|=> $stable(octrl_q) && $stable(slip_q) && $stable(tsens_enable_q))
		else $error("read-only write changed state");
	a_read_pulse: assert property (reg_rd_en |=> reg_rvalid_q)
		else $error("read not answered");
	a_read_idle: assert property (!reg_rd_en |=> !reg_rvalid_q && $stable(reg_rdata_q))
		else $error("read answer without request");
	a_status_read: assert property (reg_rd_en && reg_addr == 6'h1f
		|=> reg_rvalid_q && reg_rdata_q[0] == $past(locked_flag)
		&& reg_rdata_q[3:1] == $past(modulator_overflow_flags)
		&& reg_rdata_q[5] == $past(sweep_active_status))
		else $error("status read mismatch");
	a_status_rsvd: assert property (reg_rd_en && reg_addr == 6'h1f
		|=> reg_rdata_q[4] == 1'b0 && reg_rdata_q[23:6] == 18'h00000)
		else $error("status reserved bits not zero");
	a_rsvd_read: assert property (reg_rd_en && (reg_addr == 6'h1d || reg_addr == 6'h22)
		|=> reg_rdata_q == 24'h000000)
		else $error("reserved register not zero");

	// Temperature; a code only moves on an enabled strobe
	a_temp_read: assert property (reg_rd_en && reg_addr == 6'h21
		|=> reg_rdata_q == {17'h00000, $past(temp_q)})
		else $error("temperature read mismatch");
	a_temp_sat: assert property (temp_q != pmsr_pkg::RST_TEMP |-> temp_q <= 7'h07)
		else $error("temperature code out of range");
	a_temp_update: assert property (tsens_enable_q && tsens_strobe
		|=> temp_q == $past(temp_code(temp_celsius)))
		else $error("temperature not updated on strobe");
	a_temp_hold: assert property (!tsens_enable_q |=> $stable(temp_q))
		else $error("temperature changed while disabled");

	c_static_mode: cover property (octrl_q[3:0] == 4'h0 && octrl_q[7] ##1 gpo_out_q != 3'b000);
	c_quant_mode: cover property (octrl_q[3:0] == 4'ha ##1 gpo_out_q == 3'b111);
	c_temp_update: cover property (tsens_enable_q && tsens_strobe ##1 temp_q == 7'h07);
	c_forced_reset: cover property (slip_q[4] && !slip_q[5] ##1 !detector_reset_n_q);
	c_slip_active: cover property (!slip_prevention_q ##1 slip_prevention_q);
endmodule

// ### shared/pmsr_pkg.sv
// Package for the synthesizer output mux, slip control and status register bank.
// Assumes a 24-bit internal register port behind the serial interface, 6-bit word addresses.
package pmsr_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;

	// Register word addresses
	localparam logic [5:0] ADDR_OUT_CTRL  = 6'h1b;
	localparam logic [5:0] ADDR_SLIP_CTRL = 6'h1c;
	localparam logic [5:0] ADDR_RSVD_1D   = 6'h1d;
	localparam logic [5:0] ADDR_TSENS_EN  = 6'h1e;
	localparam logic [5:0] ADDR_STATUS    = 6'h1f;
	localparam logic [5:0] ADDR_RSVD_20   = 6'h20;
	localparam logic [5:0] ADDR_TEMP_RD   = 6'h21;
	localparam logic [5:0] ADDR_RSVD_22   = 6'h22;

	// Reset and fixed read values
	localparam logic [23:0] RST_OUT_CTRL  = 24'h000000;
	localparam logic [5:0]  RST_SLIP_CTRL = 6'h20;
	localparam logic [23:0] VAL_RSVD_20   = 24'h000020;
	localparam logic [6:0]  RST_TEMP      = 7'h1f;

	// Output control fields
	localparam int SEL_LSB   = 0;
	localparam int SEL_MSB   = 3;
	localparam int SDATA_LSB = 4;
	localparam int SDATA_MSB = 6;
	localparam int DRV_EN    = 7;
	localparam int DIS_LSB   = 8;
	localparam int DIS_MSB   = 10;
	localparam int OCTRL_W   = 11;

	// Slip control fields
	localparam int ADJ_LSB   = 0;
	localparam int ADJ_MSB   = 3;
	localparam int FORCE_BIT = 4;
	localparam int RSTB_BIT  = 5;
	localparam int SLIP_W    = 6;

	// Status fields
	localparam int ST_LOCK   = 0;
	localparam int ST_OVF_L  = 1;
	localparam int ST_OVF_H  = 3;
	localparam int ST_SWEEP  = 5;

	// Temperature code: floor((T+40)/17.5) = floor((2T+80)/35)
	localparam int TEMP_OFS2 = 80;
	localparam int TEMP_DIV2 = 35;
	localparam logic [6:0] TEMP_MAX = 7'h07;

	typedef enum logic [3:0] {
		PMSR_SEL_STATIC = 4'h0,
		PMSR_SEL_CLOCKS = 4'h1,
		PMSR_SEL_DETECT = 4'h2,
		PMSR_SEL_SAT    = 4'h3,
		PMSR_SEL_REFSIN = 4'h4,
		PMSR_SEL_INTEG  = 4'h6,
		PMSR_SEL_AUX    = 4'h7,
		PMSR_SEL_SWEEP  = 4'h8,
		PMSR_SEL_QUANT  = 4'ha
	} pmsr_sel_t;
endpackage

// ### test/tb_top.sv
// Self-checking bench for the output mux, slip control and status register bank.
// Assumes the design's strobe register port and one 100 MHz clock.
`timescale 1ns/1ns
module tb_top;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        reg_wr_en = 1'b0;
	logic        reg_rd_en = 1'b0;
	logic [5:0]  reg_addr = 6'h00;
	logic [23:0] reg_wdata = 24'h000000;
	logic [23:0] reg_rdata_q;
	logic        reg_rvalid_q;
	logic [3:1]  gpo_out_q;
	logic [3:1]  gpo_oe_n_q;
	logic        detector_reset_n_q;
	logic [3:0]  slip_cycle_adjust_q;
	logic        slip_prevention_q;
	logic        tsens_enable_q;
	logic        tsens_strobe = 1'b0;
	logic signed [7:0] temp_celsius = 8'sh00;
	logic [21:0] src = 22'h000000;
	logic [4:0]  stat = 5'h00;
	logic [10:0] octrl = 11'h000;
	logic [5:0]  slip = 6'h20;
	logic        pin_chk = 1'b0;
	logic [31:0] lfsr_q = 32'h6574;
	logic [31:0] rnd = 32'h6574;
	logic [23:0] rd_q[$];
	logic [11:0] pin_q[$];
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	pmsr_regs dut_u (.clk_sys, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
		.reg_rdata_q, .reg_rvalid_q, .xref_clk(src[0]), .ref_div_clk(src[1]),
		.osc_div_clk(src[2]), .detector_up_pulse(src[3]), .detector_down_pulse(src[4]),
		.lock_window(src[5]), .sat_ref_strobe(src[6]), .sat_osc_strobe(src[7]),
		.max_gain_strobe(src[8]), .sine_ref(src[9]), .synced_fraction_strobe(src[10]),
		.modulator_integrator_bits(src[13:11]), .aux_clk(src[14]), .ring_osc_test(src[15]),
		.modulator_clock(src[16]), .quantizer_out(src[19:17]), .locked_flag(stat[0]),
		.modulator_overflow_flags(stat[3:1]), .sweep_active_status(stat[4]),
		.loop_reg1_bit15(src[20]), .slip_logic_reset_n(src[21]), .tsens_strobe,
		.temp_celsius, .gpo_out_q, .gpo_oe_n_q, .detector_reset_n_q, .slip_cycle_adjust_q,
		.slip_prevention_q, .tsens_enable_q);

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected {reset, slip on, adjust, oe_n, pins} from the sources sampled at an edge
	function automatic logic [11:0] exp_pins(input logic [10:0] c, input logic [5:0] sl,
			input logic [21:0] s, input logic sw);
		logic [2:0] p;
		case (c[3:0])
			4'h0: p = c[6:4];
			4'h1: p = {s[0], s[1], s[2]};
			4'h2: p = {s[3], s[4], s[5]};
			4'h3: p = {s[6], s[7], s[8]};
			4'h4: p = {s[0], s[9], s[10]};
			4'h6: p = {s[11], s[12], s[13]};
			4'h7: p = {s[14], s[15], s[16]};
			4'h8: p = {1'b0, sw, 1'b0};
			4'ha: p = {s[19], s[18], s[17]};
			default: p = 3'b000;
		endcase
		return {sl[4] ? sl[5] : s[21], sl[5] & s[20] & (sl[3:0] != 4'h0), sl[3:0],
			c[7] ? c[10:8] : 3'b111, p};
	endfunction

	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checked %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic access(input logic w, input logic r, input logic [5:0] a,
			input logic [23:0] d, input logic [23:0] e);
		@(posedge clk_sys);
		reg_wr_en <= w;
		reg_rd_en <= r;
		reg_addr  <= a;
		reg_wdata <= d;
		if (r)
			rd_q.push_back(e);
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
		reg_rd_en <= 1'b0;
	endtask

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	// Sources change every cycle so a stale or swapped pin shows up quickly
	always @(posedge clk_sys) begin
		lfsr_q <= lfsr_next(lfsr_q);
		src <= lfsr_q[21:0];
		if (pin_chk)
			pin_q.push_back(exp_pins(octrl, slip, src, stat[4]));
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			complete_run();
		end
	end

	always @(negedge clk_sys) begin
		if (reg_rvalid_q === 1'b1) begin
			if (rd_q.size() == 0)
				check("rvalid", 24'h1, 24'h0);
			else
				check("rdata", reg_rdata_q, rd_q.pop_front());
		end
		if (pin_q.size() > 0)
			check("pins", {12'h0, detector_reset_n_q, slip_prevention_q, slip_cycle_adjust_q,
				gpo_oe_n_q, gpo_out_q}, {12'h0, pin_q.pop_front()});
	end

	initial begin
		logic [5:0]  ad[8] = '{6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h20, 6'h21, 6'h22, 6'h3f};
		logic [23:0] rv[8] = '{24'h0, 24'h20, 24'h0, 24'h0, 24'h20, 24'h1f, 24'h0, 24'h0};
		logic [23:0] wv[8] = '{24'h7ff, 24'h3f, 24'h0, 24'h1, 24'h20, 24'h1f, 24'h0, 24'h0};
		int          tc[9] = '{-128, -41, -40, -23, -22, -5, 82, 83, 127};
		int          n;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		check("reset_outs", {11'h0, gpo_out_q, gpo_oe_n_q, detector_reset_n_q,
			slip_cycle_adjust_q, slip_prevention_q, tsens_enable_q}, 24'h0003c0);
		for (int i = 0; i < 8; i++)
			access(1'b0, 1'b1, ad[i], 24'h0, rv[i]);
		for (int i = 0; i < 8; i++) begin
			access(1'b1, 1'b0, ad[i], 24'hffffff, 24'h0);
			access(1'b0, 1'b1, ad[i], 24'h0, wv[i]);
		end
		check("tsens_en", {23'h0, tsens_enable_q}, 24'h1);
		access(1'b1, 1'b1, 6'h1b, 24'h000055, 24'h0007ff);
		access(1'b0, 1'b1, 6'h1b, 24'h0, 24'h000055);
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr_next(rnd);
			@(posedge clk_sys);
			stat <= rnd[4:0];
			access(1'b0, 1'b1, 6'h1f, 24'h0, {18'h0, rnd[4], 1'b0, rnd[3:0]});
		end
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr_next(rnd);
			octrl = (i == 0) ? {4'b0001, rnd[6:4], 4'h0} : {rnd[10:4], i[3:0]};
			slip = rnd[16:11];
			access(1'b1, 1'b0, 6'h1b, {13'h0, octrl}, 24'h0);
			access(1'b1, 1'b0, 6'h1c, {18'h0, slip}, 24'h0);
			access(1'b0, 1'b1, 6'h1c, 24'h0, {18'h0, slip});
			pin_chk <= 1'b1;
			repeat (6) @(posedge clk_sys);
			pin_chk <= 1'b0;
			@(posedge clk_sys);
		end
		for (int i = 0; i < 9; i++) begin
			n = 2 * tc[i] + 80;
			n = (n < 0) ? 0 : n / 35;
			@(posedge clk_sys);
			temp_celsius <= 8'(tc[i]);
			tsens_strobe <= 1'b1;
			@(posedge clk_sys);
			tsens_strobe <= 1'b0;
			access(1'b0, 1'b1, 6'h21, 24'h0, 24'((n > 7) ? 7 : n));
		end
		// A strobe with the sensor off must leave the last code in place
		access(1'b1, 1'b0, 6'h1e, 24'h0, 24'h0);
		@(posedge clk_sys);
		temp_celsius <= 8'h80;
		tsens_strobe <= 1'b1;
		@(posedge clk_sys);
		tsens_strobe <= 1'b0;
		access(1'b0, 1'b1, 6'h21, 24'h0, 24'h000007);
		repeat (4) @(posedge clk_sys);
		complete_run();
	end
endmodule
